// file: lmd_defines.vh
// Opcode patterns, operation codes and word/cycle counts for the decoder.
`ifndef LMD_DEFINES_VH
`define LMD_DEFINES_VH

// Upper-byte opcodes.
`define LMD_UB_LACC_SHORT   8'hb9
`define LMD_UB_ZLO_LDHI     8'h6a
`define LMD_UB_ZACC_LDLO    8'h69
`define LMD_UB_LD_TSHIFT    8'h6b
`define LMD_UB_PAGE_DATA    8'h0d
`define LMD_UB_STAT_FIRST   8'h0e
`define LMD_UB_STAT_SECOND  8'h0f
`define LMD_UB_MAC          8'ha2
`define LMD_UB_MAC_MOVE     8'ha3
`define LMD_UB_MPY          8'h54
`define LMD_UB_MPY_ADD      8'h50
`define LMD_UB_MPY_SUB      8'h51
`define LMD_UB_MPY_UNS      8'h55
`define LMD_UB_NORMALIZE_OP         8'ha0
`define LMD_UB_OR_DATA      8'h6d

// Prefixes and full words.
`define LMD_PFX_AUX_DATA    5'h00
`define LMD_PFX_AUX_SHORT   5'h16
`define LMD_PFX_PAGE_IMM    7'h5e
`define LMD_NIB_LDT         4'h7
`define LMD_LDT_ONLY        4'h3
`define LMD_LDT_ACC         4'h0
`define LMD_LDT_ACC_MOVE    4'h2
`define LMD_LDT_PROD        4'h1
`define LMD_LDT_SUB         4'h4
`define LMD_PFX_AUX_LONG    13'h17e1
`define LMD_PFX_OR_SHIFT    12'hbfc
`define LMD_W_PAC           16'hbe03
`define LMD_W_OR_HIGH       16'hbe82

// Operation class codes.
`define LMD_OP_NONE          5'h00
`define LMD_OP_LACC_SHORT    5'h01
`define LMD_OP_ZLO_LDHI      5'h02
`define LMD_OP_ZACC_LDLO     5'h03
`define LMD_OP_LD_TSHIFT     5'h04
`define LMD_OP_AUX_DATA      5'h05
`define LMD_OP_AUX_SHORT     5'h06
`define LMD_OP_AUX_LONG      5'h07
`define LMD_OP_PAGE_DATA     5'h08
`define LMD_OP_PAGE_IMM      5'h09
`define LMD_OP_STAT_FIRST    5'h0a
`define LMD_OP_STAT_SECOND   5'h0b
`define LMD_OP_LDT           5'h0c
`define LMD_OP_LDT_ACC       5'h0d
`define LMD_OP_LDT_ACC_MOVE  5'h0e
`define LMD_OP_LDT_PROD      5'h0f
`define LMD_OP_LDT_SUB       5'h10
`define LMD_OP_MAC           5'h11
`define LMD_OP_MAC_MOVE      5'h12
`define LMD_OP_MPY           5'h13
`define LMD_OP_MPY_ADD       5'h14
`define LMD_OP_MPY_SUB       5'h15
`define LMD_OP_MPY_UNS       5'h16
`define LMD_OP_PAC           5'h17
`define LMD_OP_NORMALIZE_OP          5'h18
`define LMD_OP_OR_SHIFT      5'h19
`define LMD_OP_OR_HIGH       5'h1a
`define LMD_OP_OR_DATA       5'h1b

// Word and cycle counts.
`define LMD_WORDS_ONE   2'h1
`define LMD_WORDS_TWO   2'h2
`define LMD_CYC_ONE     2'h1
`define LMD_CYC_TWO     2'h2
`define LMD_CYC_THREE   2'h3

`endif

// file: lmd_decoder.v
// Decoder for the load, multiply, normalize and OR instruction slice.
`timescale 1ns/1ps
// What this block does
// RULE1: Upper byte b9 loads accumulator with 8-bit constant; zero clears it.
// RULE2: Upper byte 6a zeroes low half, loads data into high half.
// RULE3: Upper byte 69 zeroes accumulator, loads low half unsigned.
// RULE4: Upper byte 6b loads accumulator shifted by multiplicand register.
// RULE5: Aux register load from data or 8-bit immediate, one word two cycles.
// RULE6: Word bf08-bf0f loads aux register from following constant, 2/2.
// RULE7: Page pointer load from data or 9-bit immediate, one word two cycles.
// RULE8: Upper bytes 0e and 0f load first and second status registers, 1/2.
// RULE9: Nibble 7 loads multiplicand with accumulate, move, product, subtract.
// RULE10: Upper bytes a2 and a3 multiply-accumulate, two words three cycles.
// RULE11: Upper byte 54 multiplies multiplicand by data into product.
// RULE12: Upper byte 50 multiplies and adds previous product.
// RULE13: Upper byte 51 multiplies subtracting product; 55 multiplies unsigned.
// RULE14: Word be03 copies product register into accumulator.
// RULE15: Upper byte a0 normalizes accumulator with address field update.
// RULE16: Words bfc0-bfcf OR shifted following constant into accumulator, 2/2.
// RULE17: Word be82 ORs following constant shifted by sixteen, 2/2.
// RULE18: Low byte is operand addressing: direct offset or indirect mode.
// RULE19: Report word and cycle counts; second word is operand, not opcode.

`include "lmd_defines.vh"

module lmd_decoder (
  input  wire        clk,
  input  wire        arst_n,
  input  wire [15:0] fetch_word,
  input  wire        fetch_valid,
  output reg         dec_valid_reg,
  output reg  [4:0]  op_class_reg,
  output reg  [1:0]  word_count_reg,
  output reg  [1:0]  cycle_count_reg,
  output reg  [2:0]  aux_reg_select_field_reg,
  output reg  [3:0]  shift_amount_field_reg,
  output reg  [8:0]  immediate_reg,
  output reg  [7:0]  operand_address_field_reg,
  output reg         indirect_mode_reg,
  output reg  [15:0] second_word_reg,
  output reg         second_valid_reg
);

  // ********************************************************************
  // Reset release.
  // ********************************************************************
  // Reset asserts at once but releases on a clock edge, so no register
  // leaves reset in a different cycle from its neighbours.
  reg rst_meta_reg;
  reg rst_sync_n_reg;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg   <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg   <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  // ********************************************************************
  // Opcode classification.
  // ********************************************************************
  // Packs class, word count and cycle count for one opcode word.
  function [8:0] lmd_classify;
    input [15:0] w;
    reg   [4:0]  op;
    reg   [1:0]  wc;
    reg   [1:0]  cc;
    begin
      op = `LMD_OP_NONE;
      wc = `LMD_WORDS_ONE;
      cc = `LMD_CYC_ONE;
      if (w == `LMD_W_PAC) begin
        op = `LMD_OP_PAC; // [RULE14]
        wc = `LMD_WORDS_ONE;
        cc = `LMD_CYC_ONE;
      end else if (w == `LMD_W_OR_HIGH) begin
        op = `LMD_OP_OR_HIGH; // [RULE17]
        wc = `LMD_WORDS_TWO;
        cc = `LMD_CYC_TWO;
      end else if (w[15:3] == `LMD_PFX_AUX_LONG) begin
        op = `LMD_OP_AUX_LONG; // [RULE6]
        wc = `LMD_WORDS_TWO;
        cc = `LMD_CYC_TWO;
      end else if (w[15:4] == `LMD_PFX_OR_SHIFT) begin
        op = `LMD_OP_OR_SHIFT; // [RULE16]
        wc = `LMD_WORDS_TWO;
        cc = `LMD_CYC_TWO;
      end else if (w[15:9] == `LMD_PFX_PAGE_IMM) begin
        op = `LMD_OP_PAGE_IMM; // [RULE7]
        wc = `LMD_WORDS_ONE;
        cc = `LMD_CYC_TWO;
      end else if (w[15:11] == `LMD_PFX_AUX_SHORT) begin
        op = `LMD_OP_AUX_SHORT; // [RULE5]
        wc = `LMD_WORDS_ONE;
        cc = `LMD_CYC_TWO;
      end else if (w[15:11] == `LMD_PFX_AUX_DATA) begin
        op = `LMD_OP_AUX_DATA; // [RULE5]
        wc = `LMD_WORDS_ONE;
        cc = `LMD_CYC_TWO;
      end else if (w[15:12] == `LMD_NIB_LDT) begin
        case (w[11:8]) // [RULE9]
          `LMD_LDT_ONLY: begin
            op = `LMD_OP_LDT;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_LDT_ACC: begin
            op = `LMD_OP_LDT_ACC;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_LDT_ACC_MOVE: begin
            op = `LMD_OP_LDT_ACC_MOVE;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_LDT_PROD: begin
            op = `LMD_OP_LDT_PROD;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_LDT_SUB: begin
            op = `LMD_OP_LDT_SUB;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          default: begin
            op = `LMD_OP_NONE;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
        endcase
      end else begin
        case (w[15:8])
          `LMD_UB_LACC_SHORT: begin
            op = `LMD_OP_LACC_SHORT; // [RULE1]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_ZLO_LDHI: begin
            op = `LMD_OP_ZLO_LDHI; // [RULE2]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_ZACC_LDLO: begin
            op = `LMD_OP_ZACC_LDLO; // [RULE3]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_LD_TSHIFT: begin
            op = `LMD_OP_LD_TSHIFT; // [RULE4]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_PAGE_DATA: begin
            op = `LMD_OP_PAGE_DATA; // [RULE7]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_TWO;
          end
          `LMD_UB_STAT_FIRST: begin
            op = `LMD_OP_STAT_FIRST; // [RULE8]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_TWO;
          end
          `LMD_UB_STAT_SECOND: begin
            op = `LMD_OP_STAT_SECOND; // [RULE8]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_TWO;
          end
          `LMD_UB_MAC: begin
            op = `LMD_OP_MAC; // [RULE10]
            wc = `LMD_WORDS_TWO;
            cc = `LMD_CYC_THREE;
          end
          `LMD_UB_MAC_MOVE: begin
            op = `LMD_OP_MAC_MOVE; // [RULE10]
            wc = `LMD_WORDS_TWO;
            cc = `LMD_CYC_THREE;
          end
          `LMD_UB_MPY: begin
            op = `LMD_OP_MPY; // [RULE11]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_MPY_ADD: begin
            op = `LMD_OP_MPY_ADD; // [RULE12]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_MPY_SUB: begin
            op = `LMD_OP_MPY_SUB; // [RULE13]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_MPY_UNS: begin
            op = `LMD_OP_MPY_UNS; // [RULE13]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_NORMALIZE_OP: begin
            op = `LMD_OP_NORMALIZE_OP; // [RULE15]
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          `LMD_UB_OR_DATA: begin
            op = `LMD_OP_OR_DATA;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
          // Words outside the slice report one word, so an unknown opcode
          // can never swallow the word that follows it.
          default: begin
            op = `LMD_OP_NONE;
            wc = `LMD_WORDS_ONE;
            cc = `LMD_CYC_ONE;
          end
        endcase
      end
      lmd_classify = {op, wc, cc};
    end
  endfunction

  // ********************************************************************
  // Fetch sequencing.
  // ********************************************************************
  // One-hot: expecting an opcode, or expecting the operand word.
  localparam [1:0] ST_OPCODE  = 2'b01;
  localparam [1:0] ST_OPERAND = 2'b10;

  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  wire [8:0] cls = lmd_classify(fetch_word);
  wire [4:0] cls_op = cls[8:4];
  wire [1:0] cls_wc = cls[3:2];
  wire [1:0] cls_cc = cls[1:0];

  // ********************************************************************
  // Word acceptance.
  // ********************************************************************
  wire       take_opcode = fetch_valid && state_reg == ST_OPCODE;
  wire       take_operand = fetch_valid && state_reg == ST_OPERAND;

  // The second word is never decoded; it only fills the operand slot.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OPCODE: begin
        if (take_opcode && cls_wc == `LMD_WORDS_TWO) begin
          state_next = ST_OPERAND; // [RULE19]
        end
      end
      ST_OPERAND: begin
        if (take_operand) begin
          state_next = ST_OPCODE; // [RULE19]
        end
      end
      default: begin
        // A corrupted state falls back to opcode decoding.
        state_next = ST_OPCODE;
      end
    endcase
  end

  // ********************************************************************
  // Field extraction.
  // ********************************************************************
  // Next values for the decode fields, taken from the word on the bus.
  reg [2:0] aux_sel_next;
  reg [8:0] imm_next;

  always @* begin
    aux_sel_next = fetch_word[10:8]; // [RULE5]
    imm_next     = {1'b0, fetch_word[7:0]}; // [RULE1]
    // Select sits in 10:8 for short forms, in 2:0 for the long form.
    if (cls_op == `LMD_OP_AUX_LONG) begin
      aux_sel_next = fetch_word[2:0]; // [RULE6]
    end
    // Short constant 00 is a clear; page immediate keeps nine bits.
    if (cls_op == `LMD_OP_PAGE_IMM) begin
      imm_next = fetch_word[8:0]; // [RULE7]
    end
  end

  // ********************************************************************
  // Sequencing registers.
  // ********************************************************************
  always @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= ST_OPCODE;
    end else begin
      state_reg <= state_next; // [RULE19]
    end
  end

  always @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      dec_valid_reg    <= 1'b0;
      second_valid_reg <= 1'b0;
    end else begin
      dec_valid_reg    <= take_opcode;
      second_valid_reg <= take_operand; // [RULE19]
    end
  end

  // ********************************************************************
  // Decode field registers.
  // ********************************************************************
  // Fields hold until the next opcode, so the pipeline may read them late.
  always @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      op_class_reg              <= `LMD_OP_NONE;
      word_count_reg            <= `LMD_WORDS_ONE;
      cycle_count_reg           <= `LMD_CYC_ONE;
      aux_reg_select_field_reg  <= 3'h0;
      shift_amount_field_reg    <= 4'h0;
      immediate_reg             <= 9'h000;
      operand_address_field_reg <= 8'h00;
      indirect_mode_reg         <= 1'b0;
    end else if (take_opcode) begin
      op_class_reg              <= cls_op;
      word_count_reg            <= cls_wc; // [RULE19]
      cycle_count_reg           <= cls_cc; // [RULE19]
      aux_reg_select_field_reg  <= aux_sel_next; // [RULE5]
      shift_amount_field_reg    <= fetch_word[3:0]; // [RULE16]
      immediate_reg             <= imm_next; // [RULE1]
      operand_address_field_reg <= fetch_word[7:0]; // [RULE18]
      indirect_mode_reg         <= fetch_word[7]; // [RULE18]
    end
  end

  // ********************************************************************
  // Operand capture.
  // ********************************************************************
  // The operand word is stored raw; its meaning depends on the opcode.
  always @(posedge clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      second_word_reg <= 16'h0000;
    end else if (take_operand) begin
      second_word_reg <= fetch_word; // [RULE10]
    end
  end

endmodule // lmd_decoder

// file: lmd_decoder_assertions.sv
// Port-level assertions for the load and multiply decoder.
`timescale 1ns/1ps
module lmd_decoder_chk (
  input wire        clk,
  input wire        arst_n,
  input wire [15:0] fetch_word,
  input wire        fetch_valid,
  input wire        dec_valid_reg,
  input wire [4:0]  op_class_reg,
  input wire [1:0]  word_count_reg,
  input wire [2:0]  aux_reg_select_field_reg,
  input wire [3:0]  shift_amount_field_reg,
  input wire [8:0]  immediate_reg,
  input wire [7:0]  operand_address_field_reg,
  input wire        indirect_mode_reg,
  input wire [15:0] second_word_reg,
  input wire        second_valid_reg
);
  // ***
  // Own pairing tracker, so a lost or extra operand word shows up.
  // ***
  reg  [1:0] rel_cnt_reg;
  reg        pend_reg;
  wire       opnd = (dec_valid_reg && word_count_reg == 2'h2) || pend_reg;
  wire       live = rel_cnt_reg == 2'h3;
  wire       take = live && fetch_valid && !opnd;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rel_cnt_reg <= 2'h0;
      pend_reg    <= 1'b0;
    end else begin
      rel_cnt_reg <= live ? rel_cnt_reg : rel_cnt_reg + 2'h1;
      pend_reg    <= opnd && !fetch_valid;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_opcode_answer: assert property (take |=> dec_valid_reg
    && !second_valid_reg) else $error("opcode word not decoded");
  a_operand_pair: assert property (live && fetch_valid && opnd |=>
    second_valid_reg && !dec_valid_reg
    && second_word_reg == $past(fetch_word)) else $error("operand lost");
  a_idle_quiet: assert property (live && !fetch_valid |=>
    !dec_valid_reg && !second_valid_reg) else $error("pulse without word");
  a_fields_hold: assert property (live && !take |=>
    $stable(op_class_reg)) else $error("class moved without opcode");
  a_short_load: assert property (take && fetch_word[15:8] == 8'hb9 |=>
    op_class_reg == 5'h01 && immediate_reg == {1'b0, $past(fetch_word[7:0])})
    else $error("short load wrong");
  a_aux_short: assert property (take && fetch_word[15:11] == 5'h16 |=>
    op_class_reg == 5'h06
    && aux_reg_select_field_reg == $past(fetch_word[10:8]))
    else $error("aux short load wrong");
  a_page_imm: assert property (take && fetch_word[15:9] == 7'h5e |=>
    op_class_reg == 5'h09 && immediate_reg == $past(fetch_word[8:0]))
    else $error("page immediate wrong");
  a_addr_field: assert property (take |=>
    operand_address_field_reg == $past(fetch_word[7:0])
    && indirect_mode_reg == $past(fetch_word[7])) else $error("address bad");
  a_aux_long: assert property (take
    && fetch_word[15:3] == 13'h17e1 |=> op_class_reg == 5'h07
    && aux_reg_select_field_reg == $past(fetch_word[2:0]))
    else $error("aux long load wrong");
  a_shift_field: assert property (take
    && fetch_word[15:4] == 12'hbfc |=> op_class_reg == 5'h19
    && shift_amount_field_reg == $past(fetch_word[3:0]))
    else $error("shift field wrong");
endmodule // lmd_decoder_chk
bind lmd_decoder lmd_decoder_chk u_chk (.clk(clk), .arst_n(arst_n),
  .fetch_word(fetch_word), .fetch_valid(fetch_valid),
  .dec_valid_reg(dec_valid_reg), .op_class_reg(op_class_reg),
  .word_count_reg(word_count_reg),
  .aux_reg_select_field_reg(aux_reg_select_field_reg),
  .shift_amount_field_reg(shift_amount_field_reg),
  .immediate_reg(immediate_reg),
  .operand_address_field_reg(operand_address_field_reg),
  .indirect_mode_reg(indirect_mode_reg), .second_word_reg(second_word_reg),
  .second_valid_reg(second_valid_reg));

// file: lmd_fetch_model.sv
// Behavioural program-memory fetch stream feeding the decoder.
`timescale 1ns/1ps
module lmd_fetch_model (
  input  wire        clk,
  input  wire        req,
  input  wire [15:0] word_in,
  output reg         fetch_valid,
  output reg  [15:0] fetch_word
);
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = 16'h0000;
  end
  // Between words the bus inverts every cycle, alternating the inverse and the last word, so a
  // decoder that samples without the strobe sees a stale copy every other cycle.
  always @(posedge clk) begin
    fetch_valid <= req;
    fetch_word  <= req ? word_in : ~fetch_word;
  end
endmodule // lmd_fetch_model

// file: tb.sv
// Self-checking bench for the load and multiply decoder.
`timescale 1ns/1ps
module tb;
  reg         clk, arst_n, req;
  reg  [15:0] word_in;
  wire        fetch_valid, dec_valid_reg, second_valid_reg;
  wire [15:0] fetch_word, second_word_reg;
  wire [4:0]  op_class_reg;
  wire [1:0]  word_count_reg, cycle_count_reg;
  wire [8:0]  immediate_reg;
  wire [2:0]  aux_reg_select_field_reg;
  int         fails = 0, checked = 0;
  // Row: opcode word, class code, word count, cycle count.
  logic [31:0] rows [0:28] = '{
    32'hb9a50111, 32'hb9000111, 32'h6a120211, 32'h69830311, 32'h6b440411,
    32'h05120512, 32'hb7ff0612, 32'hbf0d0722, 32'h0d340812, 32'hbd550912,
    32'h0e010a12, 32'h0f020b12, 32'h73110c11, 32'h70220d11, 32'h72330e11,
    32'h71440f11, 32'h74551011, 32'ha2661123, 32'ha3771223, 32'h54881311,
    32'h50991411, 32'h51aa1511, 32'h55bb1611, 32'hbe031711, 32'ha0cc1811,
    32'hbfc71922, 32'hbe821a22, 32'h6d101b11, 32'h75000011};
  lmd_fetch_model u_mem (.clk(clk), .req(req), .word_in(word_in),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  lmd_decoder uut (.clk(clk), .arst_n(arst_n), .fetch_word(fetch_word),
    .fetch_valid(fetch_valid), .dec_valid_reg(dec_valid_reg),
    .op_class_reg(op_class_reg), .word_count_reg(word_count_reg),
    .cycle_count_reg(cycle_count_reg),
    .aux_reg_select_field_reg(aux_reg_select_field_reg),
    .shift_amount_field_reg(), .immediate_reg(immediate_reg),
    .operand_address_field_reg(), .indirect_mode_reg(),
    .second_word_reg(second_word_reg), .second_valid_reg(second_valid_reg));
  task automatic chk(input string n, input logic [15:0] g, e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    word_in <= w;
    req     <= 1'b1;
  endtask
  task automatic idle;
    @(posedge clk);
    req <= 1'b0;
  endtask
  task automatic wait_on(input bit sec);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(sec ? second_valid_reg === 1'b1 : dec_valid_reg === 1'b1)
               && n < 8);
    chk("pulse", {15'h0, n < 8}, 16'h1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // The whole run needs well under a thousand cycles; this is ample margin.
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  initial begin
    logic [31:0] r;
    arst_n  = 1'b0;
    req     = 1'b0;
    word_in = 16'h0000;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 29; i++) begin
      r = rows[i];
      send(r[31:16]);
      idle;
      wait_on(1'b0);
      chk("class", op_class_reg, r[12:8]);
      chk("words", word_count_reg, r[5:4]);
      chk("cycles", cycle_count_reg, r[1:0]);
      if (r[5:4] == 2'h2) begin
        send(16'hb900 + i[15:0]);
        idle;
        wait_on(1'b1);
        chk("operand", second_word_reg, 16'hb900 + i[15:0]);
      end
    end
    // Back-to-back words: a two-word form, a short load, then a MAC.
    send(16'hbf0d);
    send(16'h1234);
    send(16'hb9ff);
    send(16'ha266);
    #1;
    chk("b2b long", op_class_reg, 16'h07);
    chk("b2b select", aux_reg_select_field_reg, 16'h5);
    send(16'h5678);
    #1;
    chk("b2b operand", second_word_reg, 16'h1234);
    chk("b2b short", immediate_reg, 16'h00ff);
    idle;
    #1;
    chk("b2b mac", cycle_count_reg, 16'h3);
    @(posedge clk);
    #1;
    chk("b2b pair", second_word_reg, 16'h5678);
    // Reset between an opcode and its operand must drop the pairing.
    send(16'ha377);
    idle;
    wait_on(1'b0);
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    chk("rst words", word_count_reg, 16'h1);
    chk("rst class", op_class_reg, 16'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    send(16'hb912);
    idle;
    wait_on(1'b0);
    chk("after rst", immediate_reg, 16'h0012);
    wrap_up;
  end
endmodule // tb
